/* File: rxs_defines.svh */
// Constants for the receive strength and gain control block
`ifndef RXS_DEFINES_SVH
`define RXS_DEFINES_SVH

`define OCP_LOW_LAST_CODE  5'h0F
`define OCP_SAT_FIRST_CODE 5'h1B
`define OCP_LOW_BASE_MA    8'h2D
`define OCP_LOW_STEP_MA    8'h05
`define OCP_HIGH_STEP_MA   9'h00A
`define OCP_HIGH_SUB_MA    9'h01E
`define OCP_MAX_MA         8'hF0

`define GAIN_CODE_G1       3'h1
`define GAIN_CODE_G2       3'h2
`define GAIN_CODE_G3       3'h3
`define GAIN_CODE_G4       3'h4
`define GAIN_CODE_G5       3'h6
`define GAIN_CODE_G6       3'h7
`define GAIN_DB_G1         8'h00
`define GAIN_DB_G2         8'hFA
`define GAIN_DB_G3         8'hF4
`define GAIN_DB_G4         8'hE8
`define GAIN_DB_G5         8'hE6
`define GAIN_DB_G6         8'hD0

`define STRENGTH_MAX       10'h0FF
`define PKT_AVG_SHIFT      3

`endif

/* File: rxs_pkg.sv */
// Types shared by the receive strength and gain control block
package rxs_pkg;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_WAITING,
        RX_RUNNING
    } rx_state_t;

    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
        logic [7:0] third;
        logic [7:0] fourth;
        logic [7:0] last;
    } agc_thresholds_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rx_data_t;

endpackage

/* File: rx_strength_ctrl.sv */
// Receive strength measurement, gain step choice and current limit decode
`include "rxs_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rx_strength_ctrl (
    input  wire logic                      CLOCK,
    input  wire logic                      ARST_N,
    input  wire logic [4:0]                PA_CURRENT_LIMIT_CODE,
    output logic      [7:0]                PA_CURRENT_LIMIT_MA,
    input  wire logic                      RX_MODE_ON,
    input  wire logic                      DETECT_ON_PREAMBLE,
    input  wire logic                      PREAMBLE_FOUND,
    input  wire logic [7:0]                STRENGTH_DETECT_LEVEL,
    input  wire rxs_pkg::rx_data_t         RX_DATA_IN,
    output rxs_pkg::rx_data_t              RX_DATA_OUT,
    output logic                           RX_ACTIVE,
    input  wire rxs_pkg::agc_thresholds_t  AGC_THRESHOLDS,
    output logic      [2:0]                LNA_GAIN_STEP_CODE,
    output logic      [7:0]                LNA_GAIN_DB,
    input  wire logic                      SAMPLE_VALID,
    input  wire logic [7:0]                STRENGTH_SAMPLE,
    input  wire logic [4:0]                STRENGTH_COMPENSATION_OFFSET,
    input  wire logic [2:0]                STRENGTH_AVERAGE_COUNT_CODE,
    input  wire logic                      CAL_START,
    output logic      [7:0]                FSK_STRENGTH_READING,
    output logic                           STRENGTH_VALID,
    input  wire logic                      HEADER_VALID_EVENT,
    input  wire logic                      RECEIVE_DONE_EVENT,
    input  wire logic [7:0]                PACKET_NOISE_RATIO_IN,
    output logic      [7:0]                INSTANT_STRENGTH,
    output logic      [7:0]                PACKET_STRENGTH_AVERAGE,
    output logic      [7:0]                PACKET_NOISE_RATIO
);
    import rxs_pkg::*;

    logic rst_meta_r;
    logic rst_n;

    // Reset is applied at once but released only after two clean edges
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    function automatic logic [7:0] limit_ma(input logic [4:0] code);
        logic [8:0] hi;
        hi = 9'h000;
        if (code <= `OCP_LOW_LAST_CODE) begin
            limit_ma = `OCP_LOW_BASE_MA
                     + 8'({3'h0, code} * `OCP_LOW_STEP_MA);
        end else if (code <= `OCP_SAT_FIRST_CODE) begin
            hi = 9'({4'h0, code} * `OCP_HIGH_STEP_MA) - `OCP_HIGH_SUB_MA;
            limit_ma = hi[7:0];
        end else begin
            limit_ma = `OCP_MAX_MA;
        end
    endfunction

    // Current limit decode
    logic [7:0] limit_nxt;

    always_comb begin
        limit_nxt = limit_ma(PA_CURRENT_LIMIT_CODE);
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            PA_CURRENT_LIMIT_MA <= `OCP_LOW_BASE_MA;
        end else if (!rst_n) begin
            PA_CURRENT_LIMIT_MA <= `OCP_LOW_BASE_MA;
        end else begin
            PA_CURRENT_LIMIT_MA <= limit_nxt;
        end
    end

    // Receiver enabled / active sequencing
    rx_state_t state_r;
    rx_state_t state_nxt;
    rx_data_t  data_nxt;
    logic      criterion;

    // Smaller reading means stronger signal
    always_comb begin
        criterion = DETECT_ON_PREAMBLE ? PREAMBLE_FOUND
                  : (STRENGTH_VALID
                     && FSK_STRENGTH_READING <= STRENGTH_DETECT_LEVEL);
    end

    always_comb begin
        state_nxt = state_r;
        data_nxt  = '0;
        unique case (state_r)
            RX_IDLE: begin
                if (RX_MODE_ON) begin
                    state_nxt = RX_WAITING;
                end
            end
            RX_WAITING: begin
                if (!RX_MODE_ON) begin
                    state_nxt = RX_IDLE;
                end else if (criterion) begin
                    state_nxt = RX_RUNNING;
                end
            end
            RX_RUNNING: begin
                if (!RX_MODE_ON) begin
                    state_nxt = RX_IDLE;
                end else begin
                    data_nxt = RX_DATA_IN;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r     <= RX_IDLE;
            RX_DATA_OUT <= '0;
            RX_ACTIVE   <= 1'b0;
        end else if (!rst_n) begin
            state_r     <= RX_IDLE;
            RX_DATA_OUT <= '0;
            RX_ACTIVE   <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            RX_DATA_OUT <= data_nxt;
            RX_ACTIVE   <= (state_nxt == RX_RUNNING);
        end
    end

    // Gain step choice; samples count up as the input gets weaker
    logic [2:0] gain_code_nxt;
    logic [7:0] gain_db_nxt;

    always_comb begin
        gain_code_nxt = LNA_GAIN_STEP_CODE;
        gain_db_nxt   = LNA_GAIN_DB;
        if (SAMPLE_VALID) begin
            if (STRENGTH_SAMPLE >= AGC_THRESHOLDS.first) begin
                gain_code_nxt = `GAIN_CODE_G1;
                gain_db_nxt   = `GAIN_DB_G1;
            end else if (STRENGTH_SAMPLE >= AGC_THRESHOLDS.second) begin
                gain_code_nxt = `GAIN_CODE_G2;
                gain_db_nxt   = `GAIN_DB_G2;
            end else if (STRENGTH_SAMPLE >= AGC_THRESHOLDS.third) begin
                gain_code_nxt = `GAIN_CODE_G3;
                gain_db_nxt   = `GAIN_DB_G3;
            end else if (STRENGTH_SAMPLE >= AGC_THRESHOLDS.fourth) begin
                gain_code_nxt = `GAIN_CODE_G4;
                gain_db_nxt   = `GAIN_DB_G4;
            end else if (STRENGTH_SAMPLE >= AGC_THRESHOLDS.last) begin
                gain_code_nxt = `GAIN_CODE_G5;
                gain_db_nxt   = `GAIN_DB_G5;
            end else begin
                gain_code_nxt = `GAIN_CODE_G6;
                gain_db_nxt   = `GAIN_DB_G6;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            LNA_GAIN_STEP_CODE <= `GAIN_CODE_G1;
            LNA_GAIN_DB        <= `GAIN_DB_G1;
        end else if (!rst_n) begin
            LNA_GAIN_STEP_CODE <= `GAIN_CODE_G1;
            LNA_GAIN_DB        <= `GAIN_DB_G1;
        end else begin
            LNA_GAIN_STEP_CODE <= gain_code_nxt;
            LNA_GAIN_DB        <= gain_db_nxt;
        end
    end

    // Windowed strength average; window length sets settling time
    logic [15:0] acc_r;
    logic [15:0] acc_nxt;
    logic [8:0]  cnt_r;
    logic [8:0]  cnt_nxt;
    logic [2:0]  code_r;
    logic [7:0]  reading_nxt;
    logic        valid_nxt;
    logic [8:0]  win_len;
    logic [15:0] avg;
    logic [9:0]  sum;
    logic [3:0]  win_exp;
    logic [15:0] win_sum;

    always_comb begin
        // Four bits so the widest window (code 7) does not wrap to one
        win_exp     = {1'b0, STRENGTH_AVERAGE_COUNT_CODE} + 4'h1;
        win_len     = 9'h001 << win_exp;
        avg         = win_sum >> win_exp;
        // Offset after averaging so a change shows on the next result
        sum = {2'b00, avg[7:0]}
            + {{5{STRENGTH_COMPENSATION_OFFSET[4]}},
               STRENGTH_COMPENSATION_OFFSET};
        acc_nxt     = acc_r;
        cnt_nxt     = cnt_r;
        reading_nxt = FSK_STRENGTH_READING;
        valid_nxt   = STRENGTH_VALID;
        if (CAL_START || code_r != STRENGTH_AVERAGE_COUNT_CODE) begin
            acc_nxt   = 16'h0000;
            cnt_nxt   = 9'h000;
            valid_nxt = 1'b0;
        end else if (SAMPLE_VALID) begin
            acc_nxt = acc_r + {8'h00, STRENGTH_SAMPLE};
            cnt_nxt = cnt_r + 9'h001;
            if (cnt_nxt == win_len) begin
                valid_nxt = 1'b1;
                cnt_nxt   = 9'h000;
                acc_nxt   = 16'h0000;
                // Clamp rather than wrap at either end of the scale
                if (sum[9]) begin
                    reading_nxt = 8'h00;
                end else if (sum > `STRENGTH_MAX) begin
                    reading_nxt = 8'hFF;
                end else begin
                    reading_nxt = sum[7:0];
                end
            end
        end
    end

    // Recompute the average the same cycle the window closes
    always_comb begin
        win_sum = acc_r + {8'h00, STRENGTH_SAMPLE};
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            acc_r                <= 16'h0000;
            cnt_r                <= 9'h000;
            code_r               <= 3'h0;
            FSK_STRENGTH_READING <= 8'hFF;
            STRENGTH_VALID       <= 1'b0;
        end else if (!rst_n) begin
            acc_r                <= 16'h0000;
            cnt_r                <= 9'h000;
            code_r               <= 3'h0;
            FSK_STRENGTH_READING <= 8'hFF;
            STRENGTH_VALID       <= 1'b0;
        end else begin
            acc_r                <= acc_nxt;
            cnt_r                <= cnt_nxt;
            code_r               <= STRENGTH_AVERAGE_COUNT_CODE;
            FSK_STRENGTH_READING <= reading_nxt;
            STRENGTH_VALID       <= valid_nxt;
        end
    end

    // Long range readings: instantaneous and per-packet average
    logic       in_pkt_r;
    logic       in_pkt_nxt;
    logic [7:0] pkt_avg_r;
    logic [7:0] pkt_avg_nxt;
    logic [7:0] inst_nxt;
    logic [7:0] pkt_out_nxt;
    logic [7:0] snr_nxt;
    logic [8:0] diff;

    always_comb begin
        inst_nxt    = SAMPLE_VALID ? STRENGTH_SAMPLE : INSTANT_STRENGTH;
        in_pkt_nxt  = in_pkt_r;
        pkt_avg_nxt = pkt_avg_r;
        pkt_out_nxt = PACKET_STRENGTH_AVERAGE;
        snr_nxt     = PACKET_NOISE_RATIO;
        diff = {1'b0, STRENGTH_SAMPLE} - {1'b0, pkt_avg_r};
        if (HEADER_VALID_EVENT) begin
            in_pkt_nxt  = 1'b1;
            pkt_avg_nxt = STRENGTH_SAMPLE;
        end else if (in_pkt_r && SAMPLE_VALID) begin
            // First-order smoothing avoids a divider per packet length
            pkt_avg_nxt = pkt_avg_r
                + 8'($signed(diff) >>> `PKT_AVG_SHIFT);
        end
        if (RECEIVE_DONE_EVENT && in_pkt_r) begin
            in_pkt_nxt  = 1'b0;
            pkt_out_nxt = pkt_avg_nxt;
            snr_nxt     = PACKET_NOISE_RATIO_IN;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            in_pkt_r                <= 1'b0;
            pkt_avg_r               <= 8'h00;
            INSTANT_STRENGTH        <= 8'h00;
            PACKET_STRENGTH_AVERAGE <= 8'h00;
            PACKET_NOISE_RATIO      <= 8'h00;
        end else if (!rst_n) begin
            in_pkt_r                <= 1'b0;
            pkt_avg_r               <= 8'h00;
            INSTANT_STRENGTH        <= 8'h00;
            PACKET_STRENGTH_AVERAGE <= 8'h00;
            PACKET_NOISE_RATIO      <= 8'h00;
        end else begin
            in_pkt_r                <= in_pkt_nxt;
            pkt_avg_r               <= pkt_avg_nxt;
            INSTANT_STRENGTH        <= inst_nxt;
            PACKET_STRENGTH_AVERAGE <= pkt_out_nxt;
            PACKET_NOISE_RATIO      <= snr_nxt;
        end
    end

    property p_ocp_low;
        @(posedge CLOCK) disable iff (!rst_n)
        PA_CURRENT_LIMIT_CODE <= 5'h0F |=>
            PA_CURRENT_LIMIT_MA == 8'(45 + 5 * $past(PA_CURRENT_LIMIT_CODE));
    endproperty
    a_ocp_low: assert property (p_ocp_low)
        else $error("current limit wrong for low trim code");

    property p_ocp_high;
        @(posedge CLOCK) disable iff (!rst_n)
        PA_CURRENT_LIMIT_CODE inside {[5'h10:5'h1B]} |=>
            PA_CURRENT_LIMIT_MA == 8'(10 * $past(PA_CURRENT_LIMIT_CODE) - 30);
    endproperty
    a_ocp_high: assert property (p_ocp_high)
        else $error("current limit wrong for high trim code");

    property p_ocp_sat;
        @(posedge CLOCK) disable iff (!rst_n)
        PA_CURRENT_LIMIT_CODE > 5'h1B |=> PA_CURRENT_LIMIT_MA == 8'hF0;
    endproperty
    a_ocp_sat: assert property (p_ocp_sat)
        else $error("current limit not saturated");

    property p_wait;
        @(posedge CLOCK) disable iff (!rst_n)
        state_r != RX_RUNNING && !criterion |=> !RX_ACTIVE;
    endproperty
    a_wait: assert property (p_wait)
        else $error("receiver active without detection");

    property p_go_active;
        @(posedge CLOCK) disable iff (!rst_n)
        state_r == RX_WAITING && RX_MODE_ON && criterion
            ##1 RX_MODE_ON |=> RX_ACTIVE;
    endproperty
    a_go_active: assert property (p_go_active)
        else $error("receiver did not go active");

    property p_data_gate;
        @(posedge CLOCK) disable iff (!rst_n)
        RX_DATA_OUT.valid |-> $past(RX_ACTIVE) && $past(RX_DATA_IN.valid);
    endproperty
    a_data_gate: assert property (p_data_gate)
        else $error("data passed while not active");

    property p_gain_low;
        @(posedge CLOCK) disable iff (!rst_n)
        SAMPLE_VALID && STRENGTH_SAMPLE >= AGC_THRESHOLDS.first |=>
            LNA_GAIN_STEP_CODE == 3'h1 && LNA_GAIN_DB == 8'h00;
    endproperty
    a_gain_low: assert property (p_gain_low)
        else $error("weak input did not pick full gain");

    property p_gain_high;
        @(posedge CLOCK) disable iff (!rst_n)
        SAMPLE_VALID && STRENGTH_SAMPLE < AGC_THRESHOLDS.last |=>
            LNA_GAIN_STEP_CODE == 3'h7 && LNA_GAIN_DB == 8'hD0;
    endproperty
    a_gain_high: assert property (p_gain_high)
        else $error("strong input did not pick lowest gain");

    property p_cal;
        @(posedge CLOCK) disable iff (!rst_n)
        CAL_START |=> !STRENGTH_VALID && cnt_r == 9'h000;
    endproperty
    a_cal: assert property (p_cal)
        else $error("calibration did not restart averaging");

    property p_inst;
        @(posedge CLOCK) disable iff (!rst_n)
        SAMPLE_VALID |=> INSTANT_STRENGTH == $past(STRENGTH_SAMPLE);
    endproperty
    a_inst: assert property (p_inst)
        else $error("instantaneous strength not updated");

    property p_offset;
        @(posedge CLOCK) disable iff (!rst_n)
        valid_nxt && !STRENGTH_VALID && !sum[9] && sum <= 10'h0FF |=>
            FSK_STRENGTH_READING == $past(sum[7:0]);
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset not applied to average");

    property p_window;
        @(posedge CLOCK) disable iff (!rst_n)
        cnt_r <= 9'h100;
    endproperty
    a_window: assert property (p_window)
        else $error("average window exceeded 256 samples");

endmodule // rx_strength_ctrl

`default_nettype wire

/* File: tb_rx_strength_ctrl.sv */
// Self-checking bench of the receive strength and gain control block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rxs_pkg::*;

    logic            clock = 1'b0;
    logic            arst_n = 1'b0;
    logic [4:0]      limit_code = 5'h00;
    logic [7:0]      limit_ma;
    logic            rx_mode = 1'b0;
    logic            detect_pre = 1'b0;
    logic            pre_found = 1'b0;
    logic [7:0]      detect_level = 8'h00;
    rx_data_t        data_in = '0;
    rx_data_t        data_out;
    logic            rx_active;
    agc_thresholds_t thr = {8'hC0, 8'hA0, 8'h80, 8'h60, 8'h40};
    logic [2:0]      gain_code;
    logic [7:0]      gain_db;
    logic            sample_valid = 1'b0;
    logic [7:0]      sample = 8'h00;
    logic [4:0]      offset = 5'h00;
    logic [2:0]      avg_code = 3'h0;
    logic            cal_start = 1'b0;
    logic [7:0]      reading;
    logic            strength_valid;
    logic            header_ev = 1'b0;
    logic            done_ev = 1'b0;
    logic [7:0]      ratio_in = 8'h00;
    logic [7:0]      instant;
    logic [7:0]      pkt_avg;
    logic [7:0]      ratio_out;
    int              seed = 32'h5833_fb0a;
    int              bad_count = 0;
    int              check_count = 0;
    int              win_q[$];
    int              pkt_model = 0;
    bit              pkt_on = 1'b0;
    int              i;
    int              j;
    int              e;
    logic [2:0]      step_codes[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    int              step_db[6] = '{0, -6, -12, -24, -26, -48};

    rx_strength_ctrl uut (
        .CLOCK(clock), .ARST_N(arst_n),
        .PA_CURRENT_LIMIT_CODE(limit_code), .PA_CURRENT_LIMIT_MA(limit_ma),
        .RX_MODE_ON(rx_mode), .DETECT_ON_PREAMBLE(detect_pre),
        .PREAMBLE_FOUND(pre_found), .STRENGTH_DETECT_LEVEL(detect_level),
        .RX_DATA_IN(data_in), .RX_DATA_OUT(data_out), .RX_ACTIVE(rx_active),
        .AGC_THRESHOLDS(thr), .LNA_GAIN_STEP_CODE(gain_code),
        .LNA_GAIN_DB(gain_db), .SAMPLE_VALID(sample_valid),
        .STRENGTH_SAMPLE(sample), .STRENGTH_COMPENSATION_OFFSET(offset),
        .STRENGTH_AVERAGE_COUNT_CODE(avg_code), .CAL_START(cal_start),
        .FSK_STRENGTH_READING(reading), .STRENGTH_VALID(strength_valid),
        .HEADER_VALID_EVENT(header_ev), .RECEIVE_DONE_EVENT(done_ev),
        .PACKET_NOISE_RATIO_IN(ratio_in), .INSTANT_STRENGTH(instant),
        .PACKET_STRENGTH_AVERAGE(pkt_avg), .PACKET_NOISE_RATIO(ratio_out)
    );

    always #20 clock = ~clock;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("Checks made %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Bounded poll: sel 0 watches strength valid, sel 1 receiver active
    task automatic await(input int sel, input logic lvl);
        int k;
        for (k = 0; k < 4; k++) begin
            if ((sel == 0 ? strength_valid : rx_active) === lvl) return;
            @(negedge clock);
        end
        chk(16'(sel == 0 ? strength_valid : rx_active), 16'(lvl));
        stop_test;
    endtask

    // One strobed sample; a gap cycle follows so the strobe never
    // falls and rises in the same time step
    task automatic feed(input int s);
        int idx;
        idx = int'(s < thr.first) + int'(s < thr.second)
            + int'(s < thr.third) + int'(s < thr.fourth)
            + int'(s < thr.last);
        sample = 8'(s);
        sample_valid = 1'b1;
        @(negedge clock);
        sample_valid = 1'b0;
        chk(16'({gain_code, gain_db}),
            16'({step_codes[idx], 8'(step_db[idx])}));
        chk(16'(instant), 16'(s));
        win_q.push_back(s);
        if (pkt_on) pkt_model += (s - pkt_model) >>> 3;
        @(negedge clock);
    endtask

    // Junk samples land before the restart and must not reach the average
    task automatic window(input int code, input int off, input int base,
                          input int span, input int junk);
        int n;
        int x;
        for (n = 0; n < junk; n++) feed(base);
        avg_code = 3'(code);
        offset = 5'(off);
        cal_start = 1'b1;
        @(negedge clock);
        cal_start = 1'b0;
        chk(16'(strength_valid), 16'h0000);
        win_q.delete();
        n = 2 ** (code + 1);
        repeat (n - 1) feed(base + int'({$random(seed)} % span));
        chk(16'(strength_valid), 16'h0000);
        feed(base + int'({$random(seed)} % span));
        await(0, 1'b1);
        x = win_q.sum() / n + off;
        x = x < 0 ? 0 : (x > 255 ? 255 : x);
        chk(16'(reading), 16'(x));
    endtask

    initial begin
        repeat (12) @(negedge clock);
        chk(16'(limit_ma), 16'h002D);
        chk(16'({gain_code, gain_db}), 16'h0100);
        chk(16'({reading, strength_valid, rx_active}), 16'h03FC);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        for (i = 0; i < 64; i++) begin
            j = i < 32 ? i : int'({$random(seed)} % 32);
            limit_code = 5'(j);
            @(negedge clock);
            e = j <= 15 ? 45 + 5 * j : (j <= 27 ? 10 * j - 30 : 240);
            chk(16'(limit_ma), 16'(e));
        end
        $display("Current limit test done");
        for (i = 0; i < 2; i++) begin
            if (i == 1) thr = {8'hF0, 8'hB0, 8'h70, 8'h30, 8'h10};
            for (j = 0; j < 5; j++) begin
                feed(int'(thr[8*j +: 8]));
                feed(int'(thr[8*j +: 8]) - 1);
            end
            repeat (20) feed(int'({$random(seed)} % 256));
        end
        feed(0);
        feed(255);
        $display("Gain step test done");
        for (i = 0; i < 8; i++) begin
            window(i, int'({$random(seed)} % 32) - 16,
                   int'({$random(seed)} % 190), 64, i == 3 ? 5 : 0);
        end
        window(1, -16, 0, 10, 2);
        window(2, 15, 245, 11, 0);
        $display("Strength average test done");
        detect_pre = 1'b1;
        rx_mode = 1'b1;
        for (i = 0; i < 6; i++) begin
            data_in = {1'b1, 8'(i)};
            @(negedge clock);
            chk(16'({rx_active, data_out.valid}), 16'h0000);
        end
        pre_found = 1'b1;
        await(1, 1'b1);
        for (i = 0; i < 8; i++) begin
            j = int'({$random(seed)} % 256);
            data_in = {1'b1, 8'(j)};
            @(negedge clock);
            chk(16'(data_out), 16'({1'b1, 8'(j)}));
        end
        data_in = '0;
        rx_mode = 1'b0;
        pre_found = 1'b0;
        await(1, 1'b0);
        detect_pre = 1'b0;
        detect_level = 8'h40;
        rx_mode = 1'b1;
        window(0, 0, 128, 16, 0);
        repeat (2) @(negedge clock);
        chk(16'(rx_active), 16'h0000);
        window(0, 0, 16, 16, 0);
        await(1, 1'b1);
        rx_mode = 1'b0;
        await(1, 1'b0);
        $display("Receiver state test done");
        feed(80);
        header_ev = 1'b1;
        @(negedge clock);
        header_ev = 1'b0;
        pkt_model = 80;
        pkt_on = 1'b1;
        for (i = 0; i < 12; i++) feed(96 + 8 * i);
        ratio_in = 8'($random(seed));
        done_ev = 1'b1;
        @(negedge clock);
        done_ev = 1'b0;
        pkt_on = 1'b0;
        chk(16'(pkt_avg), 16'(pkt_model));
        chk(16'(ratio_out), 16'(ratio_in));
        feed(240);
        chk(16'(pkt_avg), 16'(pkt_model));
        $display("Packet strength test done");
        arst_n = 1'b0;
        @(negedge clock);
        chk(16'({reading, strength_valid, rx_active}), 16'h03FC);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        $display("Reset test done");
        stop_test;
    end

endmodule // tb_top

`default_nettype wire
